/* hdl/ccs_defines.svh */
// Constants for the contact closure streamer: offsets, fields, resets, timing
// Behaviour
// - Sample each contact input 100 times per second
// - Send detected changes at once, latency below 20ms
// - Repeat current state every 100 ms
// - Relay outputs open unless valid closed status; manual control while receiver disabled
// - Two channels, three copies per update
// - Transmit and receive separate, channels cross-routable
// - Modes normal, invert, force active, force inactive
// - Closed input updates payload and raises alarm
// - Alarm sent as notification and readable
// - Link alarm at both ends on failure
// - Enable gates only streaming, contacts stay usable
// - Per-receiver good or failed stream indication
// - Hop limit 0 to 127, default 10
// - Link-loss alarm after 1-1000 s, default 10
// - No-stream after 0-10000 ms silence, default 300
// - Reorder window programmable, default six entries
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
// Register byte offsets
`define CCS_CTRL_OFF       8'h00
`define CCS_MODE_OFF       8'h04
`define CCS_TTL_OFF        8'h08
`define CCS_LOSS_OFF       8'h0C
`define CCS_FAIL_OFF       8'h10
`define CCS_FILT_OFF       8'h14
`define CCS_REORD_OFF      8'h18
`define CCS_STAT_OFF       8'h1C
// Control field positions
`define CCS_CTRL_TXEN      0
`define CCS_CTRL_RXEN      2
`define CCS_CTRL_RXSEL     4
`define CCS_CTRL_MANUAL    6
// Reset values
`define CCS_TTL_RST        7'h0A
`define CCS_LOSS_RST       10'h00A
`define CCS_FAIL_RST       14'h012C
`define CCS_FILT_RST       16'h0000
`define CCS_REORD_RST      7'h06
// Timing
`define CCS_CLK_NS         50
`define CCS_MS_NS          1000000
`define CCS_SAMPLE_MS      10
`define CCS_PERIOD_MS      100
`define CCS_MS_PER_S       1000
`define CCS_COPIES         3
`endif

/* hdl/ccs_pkg.sv */
// Types shared by the contact closure streamer
package ccs_pkg;
  // Operating mode of one contact input
  typedef enum logic [1:0] {
    CCS_NORMAL    = 2'b00,
    CCS_INVERT    = 2'b01,
    CCS_FORCE_ON  = 2'b10,
    CCS_FORCE_OFF = 2'b11
  } ccs_mode_t;
  // Outgoing status packet
  typedef struct packed {
    logic [6:0] ttl;    // Hop limit
    logic       chan;   // Source channel
    logic       state;  // Closed when high
    logic [7:0] seq;    // Update sequence
  } ccs_tx_pkt_t;
  // Incoming status packet
  typedef struct packed {
    logic [15:0] src_port;  // Sender port
    logic        chan;      // Sender channel
    logic        state;     // Closed when high
    logic [7:0]  seq;       // Update sequence
  } ccs_rx_pkt_t;
endpackage

/* hdl/ccs_top.sv */
// Contact closure streamer: transmit FIFO and top level with APB registers
`timescale 1ns/1ps
`include "ccs_defines.svh"

// Synchronous FIFO with valid/ready on both sides
module ccs_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              full
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];   // Storage words
  logic [AW:0]  wr_r;          // Write pointer with wrap bit
  logic [AW:0]  rd_r;          // Read pointer with wrap bit
  wire          empty = (wr_r == rd_r);
  wire          push  = in_valid && in_ready;
  wire          pop   = out_valid && out_ready;
  assign full      = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_r[AW-1:0]];
  // Storage write
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_r[AW-1:0]] <= in_data;
  end
  // Pointer update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
    end
  end
endmodule // ccs_fifo

// Two-channel contact closure streamer
module ccs_top #(
  parameter int MS_CYCLES = `CCS_MS_NS / `CCS_CLK_NS,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [1:0]         cc_in,
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output ccs_pkg::ccs_tx_pkt_t    tx_pkt,
  input  wire logic               rx_valid,
  output logic                    rx_ready,
  input  wire ccs_pkg::ccs_rx_pkt_t rx_pkt,
  output logic [1:0]              relay_closed,
  output logic [1:0]              module_alarm,
  output logic                    alarm_notify,
  output logic                    tx_link_alarm,
  output logic [1:0]              rx_link_alarm,
  output logic [1:0]              stream_good
);
  import ccs_pkg::*;

  // Software registers
  logic [7:0]  ctrl_r;       // Enables, routing, manual relay
  logic [3:0]  mode_r;       // Two 2-bit modes
  logic [6:0]  ttl_r;        // Hop limit
  logic [9:0]  loss_r;       // Link-loss time in s
  logic [13:0] fail_r;       // Stream fail delay in ms
  logic [15:0] filt_r;       // Source port filter
  logic [6:0]  reord_r;      // Reorder window
  // Time base
  logic [$clog2(MS_CYCLES)-1:0] tick_cnt_r;  // Cycles in current ms
  logic [6:0]  ms_cnt_r;     // Ms in current 100 ms period
  logic        ms_tick;      // One cycle per ms
  logic        sample_tick;  // One cycle per 10 ms
  logic        period_tick;  // One cycle per 100 ms
  // Transmit side
  logic [1:0]  samp_r;       // Sampled, mode-applied state
  logic [1:0]  eff;          // Mode-applied live state
  logic [1:0]  cp_r [2];     // Copies still to send
  logic [7:0]  seq_r [2];    // Sequence per channel
  logic [1:0]  load;         // New update on channel
  logic        push_ch;      // Channel being pushed
  logic        push_v;       // A copy is pending
  logic        fifo_rdy;     // FIFO can take a word
  logic        fifo_full;    // FIFO full
  ccs_tx_pkt_t push_pkt;     // Word entering FIFO
  logic [19:0] tx_lost_r;    // Ms of stalled transmit
  logic [19:0] loss_ms;      // Link-loss time in ms
  // Receive side
  logic [1:0]  rx_state_r;   // Last accepted state
  logic [7:0]  rx_seq_r [2]; // Last accepted sequence
  logic [1:0]  rx_first_r;   // Nothing accepted yet
  logic [13:0] idle_r [2];   // Ms since last packet
  logic [19:0] rx_lost_r [2];// Ms without stream
  logic [1:0]  good_r;       // Stream arriving
  logic [1:0]  rx_match;     // Packet addressed to receiver
  logic [1:0]  rx_fresh;     // Packet is newer
  logic        filt_ok;      // Source port passes
  // Alarms
  logic [1:0]  alarm_r;      // Module alarm per input
  logic        notify_r;     // Alarm change pulse

  // Apply an operating mode to a raw level
  function automatic logic apply_mode(input logic [1:0] m, input logic raw);
    unique case (ccs_mode_t'(m))
      CCS_NORMAL:    apply_mode = raw;
      CCS_INVERT:    apply_mode = !raw;
      CCS_FORCE_ON:  apply_mode = 1'b1;
      CCS_FORCE_OFF: apply_mode = 1'b0;
    endcase
  endfunction

  // Time base ticks
  assign ms_tick     = (tick_cnt_r == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  assign sample_tick = ms_tick && ((ms_cnt_r % 7'(`CCS_SAMPLE_MS)) == 7'h00);
  assign period_tick = ms_tick && (ms_cnt_r == 7'h00);
  assign loss_ms     = 20'(loss_r) * 20'(`CCS_MS_PER_S);

  // Ms and period counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= 7'h00;
    end
    else
    begin
      tick_cnt_r <= ms_tick ? '0 : tick_cnt_r + 1'b1;
      if (ms_tick)
        ms_cnt_r <= (ms_cnt_r == 7'(`CCS_PERIOD_MS - 1)) ? 7'h00 : ms_cnt_r + 7'h01;
    end
  end

  // Per-channel transmit logic
  for (genvar c = 0; c < 2; c++)
  begin : g_tx
    assign eff[c]  = apply_mode(mode_r[2*c+1:2*c], cc_in[c]);
    // Change at a sample or the periodic repeat, only while enabled
    assign load[c] = ctrl_r[`CCS_CTRL_TXEN+c] && sample_tick &&
                     ((eff[c] != samp_r[c]) || period_tick);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        samp_r[c] <= 1'b0;
        cp_r[c]   <= 2'b00;
        seq_r[c]  <= 8'h00;
        alarm_r[c] <= 1'b0;
      end
      else
      begin
        if (sample_tick)
          samp_r[c] <= eff[c];
        if (sample_tick)
          alarm_r[c] <= cc_in[c];
        if (!ctrl_r[`CCS_CTRL_TXEN+c])
          cp_r[c] <= 2'b00;
        else if (load[c])
          cp_r[c] <= 2'(`CCS_COPIES);
        else if (push_v && fifo_rdy && (push_ch == 1'(c)))
          cp_r[c] <= cp_r[c] - 2'b01;
        if (load[c])
          seq_r[c] <= seq_r[c] + 8'h01;
      end
    end
  end

  // Pick a channel with copies pending, channel 0 first
  assign push_ch  = (cp_r[0] == 2'b00);
  assign push_v   = (cp_r[0] != 2'b00) || (cp_r[1] != 2'b00);
  assign push_pkt = '{ttl: ttl_r, chan: push_ch, state: samp_r[push_ch],
                      seq: seq_r[push_ch]};

  // Outgoing packet queue, drained by the network side
  ccs_fifo #(.W($bits(ccs_tx_pkt_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push_v),
    .in_ready  (fifo_rdy),
    .in_data   (push_pkt),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_pkt),
    .full      (fifo_full)
  );

  // Transmit link loss: queue blocked while streaming enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_lost_r <= 20'h00000;
    else if (!fifo_full || (ctrl_r[1:0] == 2'b00))
      tx_lost_r <= 20'h00000;
    else if (ms_tick && (tx_lost_r < loss_ms))
      tx_lost_r <= tx_lost_r + 20'h00001;
  end
  assign tx_link_alarm = (tx_lost_r >= loss_ms);

  // Receive path never stalls; unwanted packets are dropped
  assign rx_ready = 1'b1;
  assign filt_ok  = (filt_r == 16'h0000) || (rx_pkt.src_port == filt_r);

  // Per-receiver stream supervision
  for (genvar r = 0; r < 2; r++)
  begin : g_rx
    wire [7:0] diff = rx_pkt.seq - rx_seq_r[r];
    wire [7:0] back = rx_seq_r[r] - rx_pkt.seq;
    // Receiver r listens to the channel selected by software
    assign rx_match[r] = rx_valid && ctrl_r[`CCS_CTRL_RXEN+r] && filt_ok &&
                         (rx_pkt.chan == ctrl_r[`CCS_CTRL_RXSEL+r]);
    // Newer, or too far behind the window to be a late copy
    assign rx_fresh[r] = rx_first_r[r] || (diff != 8'h00 && !diff[7]) ||
                         (diff[7] && (back > {1'b0, reord_r}));
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rx_state_r[r] <= 1'b0;
        rx_seq_r[r]   <= 8'h00;
        rx_first_r[r] <= 1'b1;
        idle_r[r]     <= 14'h0000;
        good_r[r]     <= 1'b0;
        rx_lost_r[r]  <= 20'h00000;
      end
      else
      begin
        if (rx_match[r] && rx_fresh[r])
        begin
          rx_state_r[r] <= rx_pkt.state;
          rx_seq_r[r]   <= rx_pkt.seq;
          rx_first_r[r] <= 1'b0;
        end
        if (!ctrl_r[`CCS_CTRL_RXEN+r])
        begin
          idle_r[r]     <= 14'h0000;
          good_r[r]     <= 1'b0;
          rx_first_r[r] <= 1'b1;
        end
        else if (rx_match[r])
        begin
          idle_r[r] <= 14'h0000;
          good_r[r] <= 1'b1;
        end
        else if (ms_tick)
        begin
          if (idle_r[r] >= fail_r)
            good_r[r] <= 1'b0;
          else
            idle_r[r] <= idle_r[r] + 14'h0001;
        end
        if (good_r[r] || !ctrl_r[`CCS_CTRL_RXEN+r])
          rx_lost_r[r] <= 20'h00000;
        else if (ms_tick && (rx_lost_r[r] < loss_ms))
          rx_lost_r[r] <= rx_lost_r[r] + 20'h00001;
      end
    end
    assign rx_link_alarm[r] = ctrl_r[`CCS_CTRL_RXEN+r] && (rx_lost_r[r] >= loss_ms);
    // Open unless a live stream says closed; manual control when disabled
    assign relay_closed[r] = ctrl_r[`CCS_CTRL_RXEN+r] ? (good_r[r] && rx_state_r[r])
                                                      : ctrl_r[`CCS_CTRL_MANUAL+r];
  end
  assign stream_good  = good_r;
  assign module_alarm = alarm_r;

  // Notification pulse on any alarm change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      notify_r <= 1'b0;
    else
      notify_r <= sample_tick && (cc_in != alarm_r);
  end
  assign alarm_notify = notify_r;

  // APB decode: zero wait states
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire mapped  = (paddr[1:0] == 2'b00) && (paddr <= `CCS_STAT_OFF);
  wire [31:0] stat = {23'h000000, tx_link_alarm, rx_link_alarm, relay_closed,
                      good_r, alarm_r};
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Read mux
  always_comb
  begin
    unique case (paddr)
      `CCS_CTRL_OFF:  prdata = {24'h000000, ctrl_r};
      `CCS_MODE_OFF:  prdata = {28'h0000000, mode_r};
      `CCS_TTL_OFF:   prdata = {25'h0000000, ttl_r};
      `CCS_LOSS_OFF:  prdata = {22'h000000, loss_r};
      `CCS_FAIL_OFF:  prdata = {18'h00000, fail_r};
      `CCS_FILT_OFF:  prdata = {16'h0000, filt_r};
      `CCS_REORD_OFF: prdata = {25'h0000000, reord_r};
      `CCS_STAT_OFF:  prdata = stat;
      default:        prdata = 32'h00000000;
    endcase
  end

  // Register writes; out-of-range limits are clamped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r  <= 8'h00;
      mode_r  <= 4'h0;
      ttl_r   <= `CCS_TTL_RST;
      loss_r  <= `CCS_LOSS_RST;
      fail_r  <= `CCS_FAIL_RST;
      filt_r  <= `CCS_FILT_RST;
      reord_r <= `CCS_REORD_RST;
    end
    else if (wr)
    begin
      unique case (paddr)
        `CCS_CTRL_OFF:  ctrl_r  <= pwdata[7:0];
        `CCS_MODE_OFF:  mode_r  <= pwdata[3:0];
        `CCS_TTL_OFF:   ttl_r   <= pwdata[6:0];
        `CCS_LOSS_OFF:  loss_r  <= (pwdata[9:0] == 10'h000) ? 10'h001 :
                                   (pwdata[9:0] > 10'h3E8) ? 10'h3E8 : pwdata[9:0];
        `CCS_FAIL_OFF:  fail_r  <= (pwdata[13:0] > 14'h2710) ? 14'h2710 : pwdata[13:0];
        `CCS_FILT_OFF:  filt_r  <= pwdata[15:0];
        `CCS_REORD_OFF: reord_r <= pwdata[6:0];
        default:        ;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  relay_open_a: assert property (!good_r[0] && ctrl_r[2] |-> !relay_closed[0])
    else $error("relay closed without stream");
  copies_load_a: assert property (load[0] |=> cp_r[0] == 2'h3)
    else $error("copy count not loaded");
  change_sent_a: assert property (load[0] && fifo_rdy |=> push_v ##0 !push_ch)
    else $error("change not queued");
  ttl_field_a: assert property (!tx_valid && push_v |=> tx_pkt.ttl == $past(ttl_r))
    else $error("hop limit not applied");
  force_mode_a: assert property (sample_tick && mode_r[1:0] == 2'h2 |=> samp_r[0])
    else $error("force active ignored");
  alarm_follow_a: assert property (sample_tick |=> alarm_r == $past(cc_in))
    else $error("alarm does not follow input");
  alarm_notify_a: assert property (sample_tick && cc_in != alarm_r |=> alarm_notify)
    else $error("no alarm notification");
  filt_drop_a: assert property (filt_r != 16'h0 && rx_pkt.src_port != filt_r |-> rx_match == 2'b00)
    else $error("filtered packet accepted");
  tx_gate_a: assert property (!ctrl_r[0] |=> cp_r[0] == 2'b00)
    else $error("disabled channel sends");

  change_c: cover property (load[0] ##1 push_v);
  relay_c: cover property (relay_closed[0]);
  no_stream_state_c: cover property (good_r[1] ##1 !good_r[1]);
  full_c: cover property (fifo_full);
endmodule // ccs_top

/* verification/ccs_peer.sv */
// Network peer model: takes the transmit stream and injects receive packets
`timescale 1ns/1ps
module ccs_peer (
  input  wire logic                  pclk,
  input  wire logic                  stall,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire ccs_pkg::ccs_tx_pkt_t  tx_pkt,
  output logic                       rx_valid,
  output ccs_pkg::ccs_rx_pkt_t       rx_pkt
);
  import ccs_pkg::*;
  int         cnt [2];  // Words taken per channel
  int         cp  [2];  // Copies seen of the last sequence
  logic       st  [2];  // Last state per channel
  logic [7:0] sq  [2];  // Last sequence per channel
  logic [6:0] ttl;      // Last hop limit seen

  // Idle values at time zero
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_pkt   = '0;
    cnt      = '{0, 0};
    cp       = '{0, 0};
  end

  // Take words unless the bench asks for a stall
  always @(posedge pclk)
  begin
    tx_ready <= !stall;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      cnt[tx_pkt.chan] <= cnt[tx_pkt.chan] + 1;
      cp[tx_pkt.chan]  <= (sq[tx_pkt.chan] === tx_pkt.seq) ? cp[tx_pkt.chan] + 1 : 1;
      sq[tx_pkt.chan]  <= tx_pkt.seq;
      st[tx_pkt.chan]  <= tx_pkt.state;
      ttl              <= tx_pkt.ttl;
    end
  end

  // One-cycle packet strobe; a released bus shows the inverse, not stale data
  task automatic send(input logic [15:0] sp, input logic ch, input logic s, input logic [7:0] q);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_pkt   <= '{sp, ch, s, q};
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_pkt   <= ~{sp, ch, s, q};
  endtask
endmodule // ccs_peer

/* verification/testbench.sv */
// Self-checking bench for the contact closure streamer
`timescale 1ns/1ps
module testbench;
  import ccs_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [1:0]        cc_in, relay_closed, module_alarm, rx_link_alarm, stream_good;
  logic              tx_valid, tx_ready, rx_valid, rx_ready, alarm_notify, tx_link_alarm, stall, e;
  ccs_tx_pkt_t       tx_pkt;      // Outgoing word
  ccs_rx_pkt_t       rx_pkt;      // Incoming packet
  int                fail_count;  // Mismatches
  int                cmp_count;   // Comparisons
  int                notes;       // Alarm notifications seen
  int                c0;          // Snapshot of a word count
  logic [31:0]       rst_v [7];   // Register reset values

  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Count notification pulses
  always @(posedge pclk)
    if (alarm_notify === 1'b1) notes <= notes + 1;

  ccs_top #(.MS_CYCLES(4), .FIFO_DEPTH(32)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cc_in(cc_in),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pkt(tx_pkt), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_pkt(rx_pkt), .relay_closed(relay_closed), .module_alarm(module_alarm), .alarm_notify(alarm_notify),
    .tx_link_alarm(tx_link_alarm), .rx_link_alarm(rx_link_alarm), .stream_good(stream_good)
  );

  ccs_peer i_peer (
    .pclk(pclk), .stall(stall), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pkt(tx_pkt),
    .rx_valid(rx_valid), .rx_pkt(rx_pkt)
  );

  // One APB transfer; waits for pready, then releases
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, x);
      fail_count++;
    end
  endtask

  // Read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Counts, verdict and end of run
  task conclude;
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    cyc(40000);
    fail_count++;
    conclude();
  end

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cc_in, stall} = '0;
    fail_count = 0;
    cmp_count  = 0;
    notes      = 0;
    rst_v      = '{32'h0, 32'h0, 32'h0A, 32'h0A, 32'h12C, 32'h0, 32'h06};
    cyc(5);
    presetn <= 1'b1;
    // Reset values, relays open, unmapped and read-only places
    for (int i = 0; i < 7; i++) rdchk(8'(i * 4), rst_v[i]);
    rdchk(8'h1C, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    chk({31'h0, e}, 32'h0);
    rdchk(8'h1C, 32'h0);
    apb(1'b1, 8'h08, 32'hFF);
    rdchk(8'h08, 32'h7F);
    apb(1'b1, 8'h00, 32'h03);
    // Closing input: fast update, three copies, alarm and notification
    cc_in <= 2'b01;
    cyc(80);
    chk({31'h0, i_peer.st[0]}, 32'h1);
    chk(32'(i_peer.cp[0]), 32'h3);
    chk({30'h0, module_alarm}, 32'h1);
    chk(32'(notes), 32'h1);
    rdchk(8'h1C, 32'h1);
    chk({25'h0, i_peer.ttl}, 32'h7F);
    cc_in <= 2'b00;
    cyc(80);
    chk({30'h0, module_alarm}, 32'h0);
    chk({31'h0, i_peer.st[0]}, 32'h0);
    // Periodic repeat: two periods of a quiet channel
    c0 = i_peer.cnt[1];
    cyc(800);
    chk({31'h0, (i_peer.cnt[1] - c0 >= 3) && (i_peer.cnt[1] - c0 <= 9)}, 32'h1);
    // Operating modes with input closed
    cc_in <= 2'b01;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 8'h04, 32'(m));
      cyc(440);
      chk({31'h0, i_peer.st[0]}, {31'h0, (m == 0 || m == 2)});
    end
    cc_in <= 2'b00;
    // Receive: both receivers on channel 0, filter, reorder, timeout
    apb(1'b1, 8'h10, 32'h5);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h00, 32'h0F);
    i_peer.send(16'h1111, 1'b0, 1'b1, 8'h01);
    cyc(2);
    chk({30'h0, relay_closed}, 32'h3);
    chk({30'h0, stream_good}, 32'h3);
    chk({31'h0, rx_ready}, 32'h1);
    apb(1'b1, 8'h14, 32'h1234);
    i_peer.send(16'h1111, 1'b0, 1'b0, 8'h02);
    cyc(2);
    chk({30'h0, relay_closed}, 32'h3);
    i_peer.send(16'h1234, 1'b0, 1'b0, 8'h03);
    i_peer.send(16'h1234, 1'b0, 1'b1, 8'h01);
    cyc(2);
    chk({30'h0, relay_closed}, 32'h0);
    i_peer.send(16'h1234, 1'b0, 1'b1, 8'h04);
    cyc(2);
    chk({30'h0, relay_closed}, 32'h3);
    cyc(40);
    chk({30'h0, stream_good}, 32'h0);
    chk({30'h0, relay_closed}, 32'h0);
    cyc(4200);
    chk({30'h0, rx_link_alarm}, 32'h3);
    // Stalled network: buffer fills and the transmit alarm rises
    stall <= 1'b1;
    cyc(7000);
    chk({31'h0, tx_link_alarm}, 32'h1);
    chk({31'h0, tx_valid}, 32'h1);
    c0 = i_peer.cnt[0] + i_peer.cnt[1];
    stall <= 1'b0;
    cyc(100);
    chk({31'h0, tx_link_alarm}, 32'h0);
    chk({31'h0, i_peer.cnt[0] + i_peer.cnt[1] - c0 >= 32}, 32'h1);
    // Transmit disabled: no words, contact still observed
    apb(1'b1, 8'h00, 32'h0C);
    cyc(20);
    c0 = i_peer.cnt[1];
    cc_in <= 2'b10;
    cyc(500);
    chk(32'(i_peer.cnt[1] - c0), 32'h0);
    chk({30'h0, module_alarm}, 32'h2);
    // Receivers disabled: relay 0 under manual control
    apb(1'b1, 8'h00, 32'h40);
    cyc(2);
    chk({30'h0, relay_closed}, 32'h1);
    chk({30'h0, rx_link_alarm}, 32'h0);
    conclude();
  end
endmodule // testbench
